// ===== dv/afz_core_sva.sv
`timescale 1ns/10ps
module afz_core_sva (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [3:0]  light_ind_out,
  input wire logic [3:0]  pressure_ind_out,
  input wire logic        arc_binary_input_out,
  input wire logic        phase_start_out,
  input wire logic        res_start_out,
  input wire logic        phase_blocked_out,
  input wire logic        res_blocked_out,
  input wire logic [3:0]  zone_trip_out,
  input wire logic [3:0]  zone_blocked_out,
  input wire logic [3:0]  sensor_fault_out,
  input wire logic        unit_fault_out,
  input wire logic [3:0]  trip_on_evt_out,
  input wire logic [3:0]  trip_off_evt_out,
  input wire logic [3:0]  blk_on_evt_out
);
  import afz_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_trip_blk_excl: assert property ((zone_trip_out & zone_blocked_out) == 4'h0)
    else $error("trip and blocked");
  a_ph_start_blk: assert property (!(phase_start_out && phase_blocked_out))
    else $error("phase start while phase blocked");
  a_trip_on_lvl: assert property ((trip_on_evt_out & ~zone_trip_out) == 4'h0)
    else $error("trip on event without trip");
  a_trip_off_lvl: assert property ((trip_off_evt_out & zone_trip_out) == 4'h0)
    else $error("trip off event while tripped");
  a_blk_on_lvl: assert property ((blk_on_evt_out & ~zone_blocked_out) == 4'h0)
    else $error("blocked on event without blocked");
  a_evt_pulse: assert property (|trip_on_evt_out |=> trip_on_evt_out == 4'h0)
    else $error("trip on event too long");
  a_trip_rose_evt: assert property ($rose(zone_trip_out[0]) |-> ##[0:1] trip_on_evt_out[0])
    else $error("trip rose without event");
  a_tick_hold:
    assert property ($changed({zone_trip_out, zone_blocked_out, light_ind_out})
      |=> $stable({zone_trip_out, zone_blocked_out, light_ind_out})[*8])
    else $error("indication changed off tick");
  a_trip_sensor: assert property (|zone_trip_out |-> |{light_ind_out, pressure_ind_out})
    else $error("trip without light or pressure");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data when idle");
  a_status_read:
    assert property (reg_rd_in && reg_addr_in == OFS_STATUS |=> reg_rdata_out == {14'h0000,
      $past({unit_fault_out, res_blocked_out, phase_blocked_out, res_start_out,
      phase_start_out, arc_binary_input_out, sensor_fault_out, pressure_ind_out,
      light_ind_out})})
    else $error("status read differs");

  c_trip: cover property (|trip_on_evt_out);
  c_blocked: cover property (|zone_blocked_out);
  c_ph_start: cover property ($rose(phase_start_out));
endmodule

// ===== dv/afz_core_test.sv
`timescale 1ns/10ps
module afz_core_test;
  import afz_pkg::*;
  // Shortened sample gap
  localparam int SMP_GAP = 200;
  logic        clk_in, reset_n_in, reg_wr_in, reg_rd_in, sample_valid_in;
  logic        phase_block_in, res_block_in, bin_cmd, pulse_en, unit_fault_out;
  logic        arc_binary_input_in, test_pulse_in, arc_binary_input_out;
  logic        phase_start_out, res_start_out, phase_blocked_out, res_blocked_out;
  logic        fast_trip_output_one_out, fast_trip_output_two_out;
  logic [3:0]  reg_addr_in, zone_block_in, light_cmd, press_cmd, units_cmd, unit_count_in;
  logic [3:0]  light_in, pressure_in, light_ind_out, pressure_ind_out, sensor_fault_out;
  logic [3:0]  zone_trip_out, zone_blocked_out, trip_on_evt_out, trip_off_evt_out;
  logic [3:0]  blk_on_evt_out, blk_off_evt_out;
  logic [15:0] count_cmd, sensor_count_in, phase_one_samples_in, phase_two_samples_in;
  logic [15:0] phase_three_samples_in, residual_input_one_in, residual_input_two_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  int          error_cnt, num_checks, n_on, n_bin;

  afz_sensor_model mdl_u (.clk_in, .light_cmd_in(light_cmd), .press_cmd_in(press_cmd),
    .count_cmd_in(count_cmd), .units_cmd_in(units_cmd), .bin_cmd_in(bin_cmd),
    .pulse_en_in(pulse_en), .light_out(light_in), .pressure_out(pressure_in),
    .count_out(sensor_count_in), .units_out(unit_count_in), .bin_out(arc_binary_input_in),
    .test_pulse_out(test_pulse_in));

  afz_core dut_u (.clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .light_in, .pressure_in, .sensor_count_in, .unit_count_in,
    .arc_binary_input_in, .test_pulse_in, .phase_block_in, .res_block_in, .zone_block_in,
    .sample_valid_in, .phase_one_samples_in, .phase_two_samples_in, .phase_three_samples_in,
    .residual_input_one_in, .residual_input_two_in, .light_ind_out, .pressure_ind_out,
    .arc_binary_input_out, .phase_start_out, .res_start_out, .phase_blocked_out,
    .res_blocked_out, .zone_trip_out, .zone_blocked_out, .sensor_fault_out, .unit_fault_out,
    .fast_trip_output_one_out, .fast_trip_output_two_out, .trip_on_evt_out,
    .trip_off_evt_out, .blk_on_evt_out, .blk_off_evt_out);

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    n_on  += $countones(trip_on_evt_out);
    n_bin += (arc_binary_input_out === 1'b1);
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic settle();
    wt(24);
    @(negedge clk_in);
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    wt(1);
    reg_wr_in <= 1'b0;
    wt(1);
  endtask

  task automatic rd(logic [3:0] a, logic [31:0] exp);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    wt(1);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk("read data", reg_rdata_out, exp);
    wt(1);
  endtask

  task automatic smp(logic [15:0] a, b, c, d, e);
    phase_one_samples_in   <= a;
    phase_two_samples_in   <= b;
    phase_three_samples_in <= c;
    residual_input_one_in  <= d;
    residual_input_two_in  <= e;
    sample_valid_in        <= 1'b1;
    wt(1);
    sample_valid_in <= 1'b0;
    wt(SMP_GAP);
  endtask

  task automatic t_reset();
    logic [31:0] exp [7] = '{32'h0, 32'h0, 32'h0, 32'h110, 32'h7FFF, 32'h7FFF, 32'h0};
    for (int i = 0; i < 7; i++) begin
      rd(i[3:0], exp[i]);
    end
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_ind();
    for (int c = 0; c < 4; c++) begin
      light_cmd <= 4'h1 << c;
      press_cmd <= 4'h8 >> c;
      bin_cmd   <= c[0];
      settle();
      chk("light ind", light_ind_out, 4'h1 << c);
      chk("press ind", pressure_ind_out, 4'h8 >> c);
      chk("binary ind", arc_binary_input_out, c[0]);
      chk("disabled zone", zone_trip_out, 4'h0);
      wt(1);
    end
    light_cmd <= 4'h0;
    press_cmd <= 4'h0;
    bin_cmd   <= 1'b0;
    $display("t_ind done");
  endtask

  task automatic t_zone();
    logic [15:0] m;
    int          on0;
    for (int z = 0; z < 4; z++) begin
      // Other zones see every channel but stay disabled
      m = (16'hFFFF & ~(16'hF << (4 * z))) | (16'h1 << (3 * z + 3));
      wr(OFS_ZONE_CTRL, 32'h1 << z);
      wr(OFS_LIGHT_MATRIX, {16'h0, m});
      wr(OFS_PRESS_MATRIX, 32'h1 << (3 * z + 3));
      light_cmd <= ~(4'h8 >> z);
      settle();
      chk("unmapped light", zone_trip_out, 4'h0);
      wt(1);
      on0 = n_on;
      light_cmd <= 4'h8 >> z;
      settle();
      chk("trip", zone_trip_out, 4'h1 << z);
      chk("fast trip", fast_trip_output_one_out, 1'b1);
      chk("trip event", n_on - on0, 1);
      wt(1);
      zone_block_in <= 4'h1 << z;
      settle();
      chk("blocked trip", zone_trip_out, 4'h0);
      chk("blocked", zone_blocked_out, 4'h1 << z);
      wt(1);
      zone_block_in <= 4'h0;
      light_cmd     <= 4'h0;
      press_cmd     <= 4'h8 >> z;
      settle();
      chk("press trip", zone_trip_out, 4'h1 << z);
      wt(1);
      press_cmd <= 4'h0;
      settle();
      chk("trip off", zone_trip_out, 4'h0);
      wt(1);
    end
    $display("t_zone done");
  endtask

  task automatic t_curr();
    wr(OFS_ZONE_CTRL, 32'h11);
    wr(OFS_LIGHT_MATRIX, 32'h1);
    wr(OFS_PH_LIMIT, 32'h64);
    wr(OFS_RES_LIMIT, 32'h64);
    wr(OFS_CURR_CFG, 32'h121);
    light_cmd <= 4'h1;
    smp(16'h64, 16'h64, 16'h64, 16'h0, 16'h0);
    settle();
    chk("light only", zone_trip_out, 4'h0);
    wt(1);
    smp(16'h0, 16'h0, 16'h65, 16'h0, 16'h0);
    settle();
    chk("one sample", phase_start_out, 1'b0);
    wt(1);
    smp(16'h65, 16'h0, 16'h0, 16'h65, 16'h0);
    settle();
    chk("phase start", phase_start_out, 1'b1);
    chk("res start", res_start_out, 1'b1);
    chk("current trip", zone_trip_out, 4'h1);
    chk("fast current", fast_trip_output_two_out, 1'b1);
    wt(1);
    phase_block_in <= 1'b1;
    settle();
    chk("ph blocked", phase_blocked_out, 1'b1);
    chk("ph start blk", phase_start_out, 1'b0);
    chk("no trip blk", zone_trip_out, 4'h0);
    chk("no zone blk", zone_blocked_out, 4'h0);
    wt(1);
    phase_block_in <= 1'b0;
    res_block_in   <= 1'b1;
    settle();
    chk("res blocked", res_blocked_out, 1'b1);
    wt(1);
    res_block_in <= 1'b0;
    wr(OFS_CURR_CFG, 32'h122);
    rd(OFS_CURR_CFG, 32'h122);
    smp(16'h0, 16'h0, 16'h0, 16'h65, 16'h0);
    settle();
    chk("res second", res_start_out, 1'b0);
    chk("ph count clear", phase_start_out, 1'b0);
    wt(1);
    light_cmd <= 4'h0;
    $display("t_curr done");
  endtask

  task automatic t_fault();
    int b0;
    wr(OFS_SENS_CFG, 32'hE4);
    wr(OFS_CURR_CFG, 32'h2114);
    count_cmd <= 16'h3200;
    units_cmd <= 4'h3;
    settle();
    chk("sensor fault", sensor_fault_out, 4'h2);
    chk("unit fault", unit_fault_out, 1'b1);
    wt(1);
    rd(OFS_STATUS, 32'h0002_0200);
    count_cmd <= 16'h3210;
    units_cmd <= 4'h2;
    settle();
    chk("sensor ok", sensor_fault_out, 4'h0);
    chk("unit ok", unit_fault_out, 1'b0);
    wt(1);
    pulse_en <= 1'b1;
    b0 = n_bin;
    wt(200);
    chk("pulse masked", n_bin - b0, 0);
    wr(OFS_CURR_CFG, 32'h2110);
    b0 = n_bin;
    wt(200);
    chk("pulse seen", n_bin > b0, 1);
    pulse_en <= 1'b0;
    $display("t_fault done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    wt(20000);
    error_cnt++;
    $display("watchdog expired");
    results();
  end

  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, sample_valid_in, phase_block_in, res_block_in} = '0;
    {bin_cmd, pulse_en, reg_addr_in, zone_block_in, light_cmd, press_cmd, units_cmd} = '0;
    {count_cmd, phase_one_samples_in, phase_two_samples_in, phase_three_samples_in} = '0;
    {residual_input_one_in, residual_input_two_in, reg_wdata_in} = '0;
    wt(4);
    reset_n_in <= 1'b1;
    wt(4);
    t_reset();
    t_ind();
    t_zone();
    t_curr();
    t_fault();
    results();
  end
endmodule

bind afz_core afz_core_sva chk_u (.clk_in, .reset_n_in, .reg_addr_in, .reg_rd_in,
  .reg_rdata_out, .light_ind_out, .pressure_ind_out, .arc_binary_input_out, .phase_start_out,
  .res_start_out, .phase_blocked_out, .res_blocked_out, .zone_trip_out, .zone_blocked_out,
  .sensor_fault_out, .unit_fault_out, .trip_on_evt_out, .trip_off_evt_out, .blk_on_evt_out);

// ===== dv/afz_sensor_model.sv
`timescale 1ns/10ps
module afz_sensor_model (
  input  wire logic        clk_in,
  input  wire logic [3:0]  light_cmd_in,
  input  wire logic [3:0]  press_cmd_in,
  input  wire logic [15:0] count_cmd_in,
  input  wire logic [3:0]  units_cmd_in,
  input  wire logic        bin_cmd_in,
  input  wire logic        pulse_en_in,
  output logic      [3:0]  light_out,
  output logic      [3:0]  pressure_out,
  output logic      [15:0] count_out,
  output logic      [3:0]  units_out,
  output logic             bin_out,
  output logic             test_pulse_out
);
  logic [5:0] pls_ff;

  // Pulse outlasts a program cycle
  always_ff @(posedge clk_in) begin
    pls_ff <= pulse_en_in ? pls_ff + 6'h01 : 6'h00;
  end

  assign test_pulse_out = pulse_en_in && (pls_ff > 6'h2C);
  assign bin_out        = bin_cmd_in || test_pulse_out;
  assign light_out      = light_cmd_in;
  assign pressure_out   = press_cmd_in;
  assign count_out      = count_cmd_in;
  assign units_out      = units_cmd_in;
endmodule

// ===== hdl/afz_core.sv
// Notes on behaviour
// (R1) Four channels, up to three sensors each
// (R2) Light indication per channel
// (R3) Pressure indication per channel
// (R4) Binary input indication while energized
// (R5) Phase and residual start when over limit
// (R6) Current blocked indications when block input active
// (R7) Zone trips when all its conditions met
// (R8) Blocked zone shows blocked instead of trip
// (R9) Sensor fault when count differs from setting
// (R10) Unit fault when unit count differs
// (R11) Enabled current required with light
// (R12) Pressure inputs enable per zone like light
// (R13) Current condition needs configured sample count
// (R14) Three phase, two residual samples, 5 ms
// (R15) Phase, residual or both by configuration
// (R16) Zone enable and channel light matrix
// (R17) Test pulse option masks arc binary input
// (R18) Arc units send periodic wiring test pulses
// (R19) Trips go out on fast dedicated outputs; fast_trip_output_two_out carries the current condition, not a trip
// (R20) Four zones, disabled after reset
// (R21) Residual source none, first or second
// (R22) Trip is enable, sensors, currents, not blocked
// (R23) Recompute per program cycle, events on change
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module afz_core (
  input  wire logic                              clk_in,
  input  wire logic                              reset_n_in,
  input  wire logic [afz_pkg::REG_ADDR_W-1:0]    reg_addr_in,
  input  wire logic [afz_pkg::REG_DATA_W-1:0]    reg_wdata_in,
  input  wire logic                              reg_wr_in,
  input  wire logic                              reg_rd_in,
  output logic      [afz_pkg::REG_DATA_W-1:0]    reg_rdata_out,
  input  wire logic [afz_pkg::NUM_CHANNELS-1:0]  light_in,
  input  wire logic [afz_pkg::NUM_CHANNELS-1:0]  pressure_in,
  input  wire logic [4*afz_pkg::NUM_CHANNELS-1:0] sensor_count_in,
  input  wire logic [afz_pkg::UNIT_CNT_W-1:0]    unit_count_in,
  input  wire logic                              arc_binary_input_in,
  input  wire logic                              test_pulse_in,
  input  wire logic                              phase_block_in,
  input  wire logic                              res_block_in,
  input  wire logic [afz_pkg::NUM_ZONES-1:0]     zone_block_in,
  input  wire logic                              sample_valid_in,
  input  wire logic [afz_pkg::SAMPLE_W-1:0]      phase_one_samples_in,
  input  wire logic [afz_pkg::SAMPLE_W-1:0]      phase_two_samples_in,
  input  wire logic [afz_pkg::SAMPLE_W-1:0]      phase_three_samples_in,
  input  wire logic [afz_pkg::SAMPLE_W-1:0]      residual_input_one_in,
  input  wire logic [afz_pkg::SAMPLE_W-1:0]      residual_input_two_in,
  output logic [afz_pkg::NUM_CHANNELS-1:0]       light_ind_out,
  output logic [afz_pkg::NUM_CHANNELS-1:0]       pressure_ind_out,
  output logic                                   arc_binary_input_out,
  output logic                                   phase_start_out,
  output logic                                   res_start_out,
  output logic                                   phase_blocked_out,
  output logic                                   res_blocked_out,
  output logic [afz_pkg::NUM_ZONES-1:0]          zone_trip_out,
  output logic [afz_pkg::NUM_ZONES-1:0]          zone_blocked_out,
  output logic [afz_pkg::NUM_CHANNELS-1:0]       sensor_fault_out,
  output logic                                   unit_fault_out,
  output logic                                   fast_trip_output_one_out,
  output logic                                   fast_trip_output_two_out,
  output logic [afz_pkg::NUM_ZONES-1:0]          trip_on_evt_out,
  output logic [afz_pkg::NUM_ZONES-1:0]          trip_off_evt_out,
  output logic [afz_pkg::NUM_ZONES-1:0]          blk_on_evt_out,
  output logic [afz_pkg::NUM_ZONES-1:0]          blk_off_evt_out
);
  import afz_pkg::*;

  localparam int NSYNC = 2 * NUM_CHANNELS + 4 + NUM_ZONES;

  function automatic logic over_limit(input logic [SAMPLE_W-1:0] s,
                                      input logic [SAMPLE_W-1:0] lim);
    over_limit = s > lim;
  endfunction

  // Reset release
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Pin inputs: three stages, change accepted when 2nd and 3rd agree
  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] s1_ff;
  logic [NSYNC-1:0] s2_ff;
  logic [NSYNC-1:0] s3_ff;
  logic [NSYNC-1:0] pin_ff;
  logic [NSYNC-1:0] nxt_pin;
  assign raw_pins = {zone_block_in, res_block_in, phase_block_in, test_pulse_in,
                     arc_binary_input_in, pressure_in, light_in};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      assign nxt_pin[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : pin_ff[gi];
    end
  endgenerate
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      pin_ff <= '0;
    end else begin
      s1_ff  <= raw_pins;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      pin_ff <= nxt_pin;
    end
  end
  logic [NUM_CHANNELS-1:0] light_s;
  logic [NUM_CHANNELS-1:0] press_s;
  logic                    abi_s;
  logic                    tpulse_s;
  logic                    ph_blk_s;
  logic                    res_blk_s;
  logic [NUM_ZONES-1:0]    zblk_s;
  assign light_s   = pin_ff[NUM_CHANNELS-1:0];
  assign press_s   = pin_ff[2*NUM_CHANNELS-1:NUM_CHANNELS];
  assign abi_s     = pin_ff[2*NUM_CHANNELS];
  assign tpulse_s  = pin_ff[2*NUM_CHANNELS+1];
  assign ph_blk_s  = pin_ff[2*NUM_CHANNELS+2];
  assign res_blk_s = pin_ff[2*NUM_CHANNELS+3];
  assign zblk_s    = pin_ff[NSYNC-1:2*NUM_CHANNELS+4];

  // Configuration registers
  logic [31:0] zone_ctrl_ff;
  logic [15:0] light_mtx_ff;
  logic [15:0] press_mtx_ff;
  logic [31:0] curr_cfg_ff;
  logic [15:0] ph_lim_ff;
  logic [15:0] res_lim_ff;
  logic [7:0]  sens_cfg_ff;
  logic        wr_zone;
  logic        wr_light;
  logic        wr_press;
  logic        wr_curr;
  logic        wr_phl;
  logic        wr_resl;
  logic        wr_sens;
  assign wr_zone  = reg_wr_in && reg_addr_in == OFS_ZONE_CTRL;
  assign wr_light = reg_wr_in && reg_addr_in == OFS_LIGHT_MATRIX;
  assign wr_press = reg_wr_in && reg_addr_in == OFS_PRESS_MATRIX;
  assign wr_curr  = reg_wr_in && reg_addr_in == OFS_CURR_CFG;
  assign wr_phl   = reg_wr_in && reg_addr_in == OFS_PH_LIMIT;
  assign wr_resl  = reg_wr_in && reg_addr_in == OFS_RES_LIMIT;
  assign wr_sens  = reg_wr_in && reg_addr_in == OFS_SENS_CFG;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      zone_ctrl_ff <= RST_ZONE_CTRL; // [R20]
      light_mtx_ff <= RST_MATRIX;
      press_mtx_ff <= RST_MATRIX;
      curr_cfg_ff  <= RST_CURR_CFG;  // [R21]
      ph_lim_ff    <= RST_LIMIT;
      res_lim_ff   <= RST_LIMIT;
      sens_cfg_ff  <= RST_SENS_CFG;
    end else begin
      if (wr_zone)  zone_ctrl_ff <= {20'h00000, reg_wdata_in[11:0]};
      if (wr_light) light_mtx_ff <= reg_wdata_in[15:0];
      if (wr_press) press_mtx_ff <= reg_wdata_in[15:0];
      if (wr_curr)  curr_cfg_ff  <= {16'h0000, reg_wdata_in[15:0]};
      if (wr_phl)   ph_lim_ff    <= reg_wdata_in[15:0];
      if (wr_resl)  res_lim_ff   <= reg_wdata_in[15:0];
      if (wr_sens)  sens_cfg_ff  <= reg_wdata_in[7:0];
    end
  end
  logic [NUM_ZONES-1:0] zone_en;
  logic [NUM_ZONES-1:0] zone_ph_en;
  logic [NUM_ZONES-1:0] zone_res_en;
  logic [1:0]           res_sel;
  logic                 tpulse_opt;
  logic [COUNT_W-1:0]   ph_need;
  logic [COUNT_W-1:0]   res_need;
  logic [UNIT_CNT_W-1:0] units_cfg;
  assign zone_en     = zone_ctrl_ff[ZC_EN_LSB +: NUM_ZONES];
  assign zone_ph_en  = zone_ctrl_ff[ZC_PH_LSB +: NUM_ZONES];
  assign zone_res_en = zone_ctrl_ff[ZC_RES_LSB +: NUM_ZONES];
  assign res_sel     = curr_cfg_ff[CC_RES_SEL_LSB +: 2];
  assign tpulse_opt  = curr_cfg_ff[CC_TEST_PLS_BIT];
  assign ph_need     = curr_cfg_ff[CC_PH_NUM_LSB +: COUNT_W];
  assign res_need    = curr_cfg_ff[CC_RES_NUM_LSB +: COUNT_W];
  assign units_cfg   = curr_cfg_ff[CC_UNITS_LSB +: UNIT_CNT_W];

  // Current condition: consecutive over-limit sample count per 5 ms sample [R14]
  logic [COUNT_W-1:0] ph_cnt_ff;
  logic [COUNT_W-1:0] res_cnt_ff;
  logic [COUNT_W-1:0] nxt_ph_cnt;
  logic [COUNT_W-1:0] nxt_res_cnt;
  logic               ph_over;
  logic               res_over;
  logic [SAMPLE_W-1:0] res_sample;
  assign ph_over = over_limit(phase_one_samples_in, ph_lim_ff)
                || over_limit(phase_two_samples_in, ph_lim_ff)
                || over_limit(phase_three_samples_in, ph_lim_ff);
  assign res_sample = (res_sel == AFZ_RES_ONE) ? residual_input_one_in :
                      (res_sel == AFZ_RES_TWO) ? residual_input_two_in :
                      '0; // [R21]
  assign res_over = (res_sel != AFZ_RES_NONE) && over_limit(res_sample, res_lim_ff);
  assign nxt_ph_cnt  = !sample_valid_in ? ph_cnt_ff :
                       !ph_over ? '0 :
                       (ph_cnt_ff == '1) ? ph_cnt_ff : ph_cnt_ff + 1'b1;
  assign nxt_res_cnt = !sample_valid_in ? res_cnt_ff :
                       !res_over ? '0 :
                       (res_cnt_ff == '1) ? res_cnt_ff : res_cnt_ff + 1'b1;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ph_cnt_ff  <= '0;
      res_cnt_ff <= '0;
    end else begin
      ph_cnt_ff  <= nxt_ph_cnt;
      res_cnt_ff <= nxt_res_cnt;
    end
  end
  logic ph_cond;
  logic res_cond;
  assign ph_cond  = (ph_cnt_ff != '0) && (ph_cnt_ff >= ph_need);   // [R13]
  assign res_cond = (res_cnt_ff != '0) && (res_cnt_ff >= res_need); // [R13]

  // Program cycle tick
  logic [7:0] pc_cnt_ff;
  logic       pc_tick;
  assign pc_tick = (pc_cnt_ff == 8'(PROG_CYCLE_CYCLES - 1));
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pc_cnt_ff <= '0;
    end else begin
      pc_cnt_ff <= pc_tick ? 8'h00 : pc_cnt_ff + 8'h01;
    end
  end

  // Zone decisions
  logic [NUM_ZONES-1:0] zone_cond;
  logic [NUM_ZONES-1:0] nxt_trip;
  logic [NUM_ZONES-1:0] nxt_blk;
  generate
    for (gi = 0; gi < NUM_ZONES; gi++) begin : g_zone
      logic sens_hit;
      logic curr_ok;
      assign sens_hit = |(light_s & light_mtx_ff[gi*NUM_CHANNELS +: NUM_CHANNELS])  // [R16]
                     || |(press_s & press_mtx_ff[gi*NUM_CHANNELS +: NUM_CHANNELS]); // [R12]
      assign curr_ok = (!zone_ph_en[gi] || (ph_cond && !ph_blk_s))      // [R11] [R15]
                    && (!zone_res_en[gi] || (res_cond && !res_blk_s));  // [R11] [R15]
      assign zone_cond[gi] = zone_en[gi] && sens_hit && curr_ok;        // [R7] [R22]
      assign nxt_trip[gi]  = zone_cond[gi] && !zblk_s[gi];              // [R22]
      assign nxt_blk[gi]   = zone_cond[gi] && zblk_s[gi];               // [R8]
    end
  endgenerate

  // Channel sensor faults
  logic [NUM_CHANNELS-1:0] nxt_sfault;
  generate
    for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_chan
      assign nxt_sfault[gi] = sensor_count_in[gi*4 +: 4]
                           != {2'b00, sens_cfg_ff[gi*SC_CH_W +: SC_CH_W]}; // [R1] [R9]
    end
  endgenerate

  // Indications refresh on the program tick [R23]
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      {light_ind_out, pressure_ind_out, arc_binary_input_out, phase_start_out} <= '0;
      {res_start_out, phase_blocked_out, res_blocked_out, zone_trip_out} <= '0;
      {zone_blocked_out, sensor_fault_out, unit_fault_out, trip_on_evt_out} <= '0;
      {trip_off_evt_out, blk_on_evt_out, blk_off_evt_out} <= '0;
    end else if (pc_tick) begin
      light_ind_out        <= light_s;                            // [R2]
      pressure_ind_out     <= press_s;                            // [R3]
      arc_binary_input_out <= abi_s && !(tpulse_opt && tpulse_s); // [R4] [R17]
      phase_start_out      <= ph_cond && !ph_blk_s;               // [R5]
      res_start_out        <= res_cond && !res_blk_s;             // [R5]
      phase_blocked_out    <= ph_cond && ph_blk_s;                // [R6]
      res_blocked_out      <= res_cond && res_blk_s;              // [R6]
      zone_trip_out        <= nxt_trip;
      zone_blocked_out     <= nxt_blk;
      sensor_fault_out     <= nxt_sfault;                         // [R9]
      unit_fault_out       <= unit_count_in != units_cfg;         // [R10]
      trip_on_evt_out      <= nxt_trip & ~zone_trip_out;          // [R23]
      trip_off_evt_out     <= ~nxt_trip & zone_trip_out;          // [R23]
      blk_on_evt_out       <= nxt_blk & ~zone_blocked_out;        // [R23]
      blk_off_evt_out      <= ~nxt_blk & zone_blocked_out;        // [R23]
    end else begin
      {trip_on_evt_out, trip_off_evt_out, blk_on_evt_out, blk_off_evt_out} <= '0;
    end
  end

  // Fast trip path bypasses the program cycle to cut latency
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fast_trip_output_one_out <= 1'b0;
      fast_trip_output_two_out <= 1'b0;
    end else begin
      fast_trip_output_one_out <= |nxt_trip;                     // [R19]
      fast_trip_output_two_out <= ph_cond || res_cond;           // [R19]
    end
  end

  // Register read, one cycle later; unmapped reads zero
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic [31:0] event_word;
  assign status_word = {14'h0000, unit_fault_out, res_blocked_out, phase_blocked_out,
                        res_start_out, phase_start_out, arc_binary_input_out,
                        sensor_fault_out, pressure_ind_out, light_ind_out};
  assign event_word  = {16'h0000, blk_off_evt_out, blk_on_evt_out,
                        zone_blocked_out, zone_trip_out};
  assign rd_mux = reg_addr_in == OFS_ZONE_CTRL    ? zone_ctrl_ff :
                  reg_addr_in == OFS_LIGHT_MATRIX ? {16'h0000, light_mtx_ff} :
                  reg_addr_in == OFS_PRESS_MATRIX ? {16'h0000, press_mtx_ff} :
                  reg_addr_in == OFS_CURR_CFG     ? curr_cfg_ff :
                  reg_addr_in == OFS_PH_LIMIT     ? {16'h0000, ph_lim_ff} :
                  reg_addr_in == OFS_RES_LIMIT    ? {16'h0000, res_lim_ff} :
                  reg_addr_in == OFS_SENS_CFG     ? {24'h000000, sens_cfg_ff} :
                  reg_addr_in == OFS_STATUS       ? status_word :
                  reg_addr_in == OFS_EVENTS       ? event_word : 32'h0000_0000;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
    end
  end
endmodule

// ===== hdl/afz_pkg.sv
package afz_pkg;
  localparam int NUM_CHANNELS     = 4;
  localparam int NUM_ZONES        = 4;
  localparam int SAMPLE_W         = 16;
  localparam int COUNT_W          = 4;
  localparam int UNIT_CNT_W       = 4;
  localparam int REG_ADDR_W       = 4;
  localparam int REG_DATA_W       = 32;
  localparam int PROG_CYCLE_CYCLES = 10;
  localparam logic [3:0] OFS_ZONE_CTRL    = 4'h0;
  localparam logic [3:0] OFS_LIGHT_MATRIX = 4'h1;
  localparam logic [3:0] OFS_PRESS_MATRIX = 4'h2;
  localparam logic [3:0] OFS_CURR_CFG     = 4'h3;
  localparam logic [3:0] OFS_PH_LIMIT     = 4'h4;
  localparam logic [3:0] OFS_RES_LIMIT    = 4'h5;
  localparam logic [3:0] OFS_SENS_CFG     = 4'h6;
  localparam logic [3:0] OFS_STATUS       = 4'h7;
  localparam logic [3:0] OFS_EVENTS       = 4'h8;
  // OFS_ZONE_CTRL fields
  localparam int ZC_EN_LSB  = 0;
  localparam int ZC_PH_LSB  = 4;
  localparam int ZC_RES_LSB = 8;
  // OFS_CURR_CFG fields
  localparam int CC_RES_SEL_LSB  = 0;
  localparam int CC_TEST_PLS_BIT = 2;
  localparam int CC_PH_NUM_LSB   = 4;
  localparam int CC_RES_NUM_LSB  = 8;
  localparam int CC_UNITS_LSB    = 12;
  // OFS_SENS_CFG: 2 bits per channel
  localparam int SC_CH_W = 2;
  localparam logic [31:0] RST_ZONE_CTRL = 32'h0000_0000;
  localparam logic [15:0] RST_MATRIX    = 16'h0000;
  localparam logic [31:0] RST_CURR_CFG  = 32'h0000_0110;
  localparam logic [15:0] RST_LIMIT     = 16'h7FFF;
  localparam logic [7:0]  RST_SENS_CFG  = 8'h00;

  typedef enum logic [1:0] {
    AFZ_RES_NONE = 2'b00,
    AFZ_RES_ONE  = 2'b01,
    AFZ_RES_TWO  = 2'b10
  } afz_res_sel_t;
endpackage
